/* File: rtl/pcd_pkg.sv */
package pcd_pkg;

  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFS_PA_RISE   = 8'h00;
  localparam logic [7:0] OFS_PA_FALL   = 8'h04;
  localparam logic [7:0] OFS_PA_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_PB_RISE   = 8'h0C;
  localparam logic [7:0] OFS_PB_FALL   = 8'h10;
  localparam logic [7:0] OFS_PB_FLAGS  = 8'h14;
  localparam logic [7:0] OFS_INT_CTRL  = 8'h18;
  localparam logic [7:0] OFS_EVT_STAT  = 8'h1C;
  localparam logic [7:0] OFS_EVT_CLR   = 8'h20;
  localparam logic [7:0] OFS_EVT_EN    = 8'h24;

  // Pin counts and field positions
  localparam int PA_W        = 6;
  localparam int PB_W        = 4;
  localparam int PB_LSB      = 4;
  localparam int CTRL_MEN    = 3;
  localparam int CTRL_SUM    = 0;
  localparam int EVT_W       = 2;
  localparam int EVT_PA      = 0;
  localparam int EVT_PB      = 1;

  // Reset values
  localparam logic [7:0] RST_ENABLE   = 8'h00;
  localparam logic [7:0] RST_FLAGS    = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // A write captured from the address and data channels
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } pcd_wreq_s;

  // Edge enables of one port
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
  } pcd_edge_cfg_s;

endpackage

/* File: rtl/pcd_edge.sv */
`timescale 1ns/100ps
// Per-pin synchroniser and edge detector
module pcd_edge #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pins and enables
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] rise_en,
  input  wire logic [W-1:0] fall_en,
  // Enabled edge seen this cycle
  output logic      [W-1:0] detect
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // Two-stage synchroniser, then one more stage to compare against
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
          prev_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= pin[i]; // RL17
          sync_ff[i] <= meta_ff[i];
          prev_ff[i] <= sync_ff[i];
        end
      end
      // Each edge is seen for exactly one cycle, so it sets a flag once
      assign detect[i] = (rise_en[i] & sync_ff[i] & ~prev_ff[i])   // RL3
                       | (fall_en[i] & ~sync_ff[i] & prev_ff[i]);  // RL4
    end
  endgenerate

endmodule

/* File: rtl/pcd_top.sv */
// Notes on behaviour
// RL1: Port A pins, and port B pins on the larger variant, may each or in any mix be change sources.
// RL2: With the master enable clear, detection and flags still work but no request reaches the core.
// RL3: Each pin has a rising-edge detector armed only by its rise enable bit.
// RL4: Each pin has a falling-edge detector armed only by its fall enable bit.
// RL5: With both enables set a pin detects edges in both directions.
// RL6: An enabled edge sets the pin flag and, with the master enable set, raises the interrupt.
// RL7: The summary flag in the control register is the OR of all pin flags of both ports.
// RL8: Writing zero to a flag clears it; flags are set by hardware and also writable.
// RL9: An edge arriving during a clearing write leaves its flag set whatever was written.
// RL10: Software should clear flags only by masking out the ones it knows have changed.
// RL11: In sleep an enabled change with the master enable set wakes the device.
// RL12: A flag for an edge seen in sleep is updated before the first instruction after wake.
// RL13: The port A rise enable holds six bits 5..0 reset to zero; bits 7..6 read zero.
// RL14: The port A fall enable holds six bits 5..0 reset to zero; a zero bit disables that direction.
// RL15: A port A flag is set by an enabled rising or an enabled falling edge on its pin.
// RL16: A flag reading zero means no enabled change or a change already cleared by software.
// RL17: Pins are synchronised and edges found by comparing the current and previous samples.
`timescale 1ns/100ps
module pcd_top #(
  parameter bit HAS_PORTB = 1'b1
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Monitored pins
  input  wire logic [5:0]  porta_pin,
  input  wire logic [3:0]  portb_pin,
  // Core side
  input  wire logic        sleep,
  output logic             pin_change_interrupt,
  output logic             wake,
  output logic             irq
);

  // Local copies keep the slices below short
  localparam int PA_W   = pcd_pkg::PA_W;
  localparam int PB_W   = pcd_pkg::PB_W;
  localparam int PB_LSB = pcd_pkg::PB_LSB;

  // Register state
  pcd_pkg::pcd_edge_cfg_s             pa_cfg_ff;
  pcd_pkg::pcd_edge_cfg_s             pb_cfg_ff;
  logic [PA_W-1:0]                    pa_flags_ff;
  logic [PB_W-1:0]                    pb_flags_ff;
  logic                               master_en_ff;
  logic [pcd_pkg::EVT_W-1:0]          evt_stat_ff;
  logic [pcd_pkg::EVT_W-1:0]          evt_en_ff;
  logic [PA_W-1:0]                    nxt_pa_flags;
  logic [PB_W-1:0]                    nxt_pb_flags;
  logic [pcd_pkg::EVT_W-1:0]          nxt_evt_stat;

  // Bus state
  pcd_pkg::pcd_wreq_s                 wreq_ff;
  logic                               aw_held_ff;
  logic                               w_held_ff;
  logic                               awready_ff;
  logic                               wready_ff;
  logic                               bvalid_ff;
  logic [1:0]                         bresp_ff;
  logic                               arready_ff;
  logic                               rvalid_ff;
  logic [1:0]                         rresp_ff;
  logic [31:0]                        rdata_ff;
  logic                               irq_core_ff;
  logic                               wake_ff;
  logic                               irq_ff;

  // Detector outputs
  logic [PA_W-1:0]                    pa_detect;
  logic [PB_W-1:0]                    pb_detect;
  logic [PB_W-1:0]                    pb_detect_raw;
  logic                               summary;
  logic                               wr_fire;
  logic                               wr_lane0;
  logic                               wr_ok;
  logic [31:0]                        rd_data;
  logic                               rd_ok;

  // Port A detectors, one per pin
  pcd_edge #(
    .W       (PA_W)
  ) u_pa_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (porta_pin),
    .rise_en (pa_cfg_ff.rise[PA_W-1:0]),
    .fall_en (pa_cfg_ff.fall[PA_W-1:0]),
    .detect  (pa_detect)
  );

  // Port B detectors, upper four bits of the port
  pcd_edge #(
    .W       (PB_W)
  ) u_pb_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (portb_pin),
    .rise_en (pb_cfg_ff.rise[PB_LSB+PB_W-1:PB_LSB]),
    .fall_en (pb_cfg_ff.fall[PB_LSB+PB_W-1:PB_LSB]),
    .detect  (pb_detect_raw)
  );

  // The small variant has no port B sources at all
  assign pb_detect = HAS_PORTB ? pb_detect_raw : '0; // RL1

  // A write happens once both channels are held and no response is pending
  assign wr_fire  = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_lane0 = wr_fire & wreq_ff.strb[0];
  assign summary  = (|pa_flags_ff) | (|pb_flags_ff); // RL7

  // Write decode: known offsets answer OKAY, port B ones only when present
  always_comb begin
    case (wreq_ff.addr)
      pcd_pkg::OFS_PA_RISE,
      pcd_pkg::OFS_PA_FALL,
      pcd_pkg::OFS_PA_FLAGS,
      pcd_pkg::OFS_INT_CTRL,
      pcd_pkg::OFS_EVT_STAT,
      pcd_pkg::OFS_EVT_CLR,
      pcd_pkg::OFS_EVT_EN:   wr_ok = 1'b1;
      pcd_pkg::OFS_PB_RISE,
      pcd_pkg::OFS_PB_FALL,
      pcd_pkg::OFS_PB_FLAGS: wr_ok = HAS_PORTB;
      default:               wr_ok = 1'b0;
    endcase
  end

  // Edge enable and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_cfg_ff    <= '{rise: pcd_pkg::RST_ENABLE, fall: pcd_pkg::RST_ENABLE}; // RL13 RL14
      pb_cfg_ff    <= '{rise: pcd_pkg::RST_ENABLE, fall: pcd_pkg::RST_ENABLE};
      master_en_ff <= 1'b0;
      evt_en_ff    <= '0;
    end else if (wr_lane0 && wr_ok) begin
      case (wreq_ff.addr)
        pcd_pkg::OFS_PA_RISE:  pa_cfg_ff.rise <= {2'h0, wreq_ff.data[PA_W-1:0]}; // RL13
        pcd_pkg::OFS_PA_FALL:  pa_cfg_ff.fall <= {2'h0, wreq_ff.data[PA_W-1:0]}; // RL14
        pcd_pkg::OFS_PB_RISE:  pb_cfg_ff.rise <= {wreq_ff.data[7:PB_LSB], 4'h0};
        pcd_pkg::OFS_PB_FALL:  pb_cfg_ff.fall <= {wreq_ff.data[7:PB_LSB], 4'h0};
        pcd_pkg::OFS_INT_CTRL: master_en_ff   <= wreq_ff.data[pcd_pkg::CTRL_MEN];
        pcd_pkg::OFS_EVT_EN:   evt_en_ff      <= wreq_ff.data[pcd_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // Flags: a software write stores its value, an edge in the same cycle still sets
  always_comb begin
    nxt_pa_flags = pa_flags_ff;
    nxt_pb_flags = pb_flags_ff;
    if (wr_lane0 && wreq_ff.addr == pcd_pkg::OFS_PA_FLAGS) begin
      nxt_pa_flags = wreq_ff.data[PA_W-1:0]; // RL8
    end
    if (wr_lane0 && wr_ok && wreq_ff.addr == pcd_pkg::OFS_PB_FLAGS) begin
      nxt_pb_flags = wreq_ff.data[PB_LSB+PB_W-1:PB_LSB]; // RL8
    end
    // Edges are merged last, so a clearing write can never hide a new edge
    nxt_pa_flags = nxt_pa_flags | pa_detect; // RL9 RL15 RL5 RL6
    nxt_pb_flags = nxt_pb_flags | pb_detect; // RL9 RL5 RL6
  end

  // Flags keep running in sleep, so they are ready before the core wakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_flags_ff <= pcd_pkg::RST_FLAGS[PA_W-1:0];
      pb_flags_ff <= pcd_pkg::RST_FLAGS[PB_W-1:0];
    end else begin
      pa_flags_ff <= nxt_pa_flags; // RL12 RL16
      pb_flags_ff <= nxt_pb_flags;
    end
  end

  // Sticky event status with write-one-to-clear; a new event beats the clear
  always_comb begin
    nxt_evt_stat = evt_stat_ff;
    if (wr_lane0 && wreq_ff.addr == pcd_pkg::OFS_EVT_CLR) begin
      nxt_evt_stat = evt_stat_ff & ~wreq_ff.data[pcd_pkg::EVT_W-1:0];
    end
    nxt_evt_stat[pcd_pkg::EVT_PA] = nxt_evt_stat[pcd_pkg::EVT_PA] | (|pa_detect);
    nxt_evt_stat[pcd_pkg::EVT_PB] = nxt_evt_stat[pcd_pkg::EVT_PB] | (|pb_detect);
  end

  // Event status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_ff <= '0;
    end else begin
      evt_stat_ff <= nxt_evt_stat;
    end
  end

  // Core request, wake and system interrupt, all registered
  // A flop on each costs one cycle of latency but gives the core clean levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_core_ff <= 1'b0;
      wake_ff     <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      irq_core_ff <= master_en_ff & summary;         // RL2 RL6
      wake_ff     <= sleep & master_en_ff & summary; // RL11
      irq_ff      <= |(evt_stat_ff & evt_en_ff);
    end
  end

  // Write channels: each is taken on its own, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      wreq_ff    <= '0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        wreq_ff.addr <= s_axi_awaddr;
        aw_held_ff   <= 1'b1;
        awready_ff   <= 1'b0;
      end else if (!aw_held_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        wreq_ff.data <= s_axi_wdata;
        wreq_ff.strb <= s_axi_wstrb;
        w_held_ff    <= 1'b1;
        wready_ff    <= 1'b0;
      end else if (!w_held_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      // Held halves are consumed by the write; ready stays low until the answer is taken
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
      end
    end
  end

  // Write response rises at the same edge that updates the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= pcd_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_ok ? pcd_pkg::RESP_OKAY : pcd_pkg::RESP_SLVERR;
    end else if (s_axi_bready && bvalid_ff) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read decode; unimplemented bits read as zero
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      pcd_pkg::OFS_PA_RISE:  rd_data[7:0] = pa_cfg_ff.rise; // RL13
      pcd_pkg::OFS_PA_FALL:  rd_data[7:0] = pa_cfg_ff.fall;
      pcd_pkg::OFS_PA_FLAGS: rd_data[PA_W-1:0] = pa_flags_ff;
      pcd_pkg::OFS_PB_RISE:  begin
        rd_data[7:0] = pb_cfg_ff.rise;
        rd_ok        = HAS_PORTB;
      end
      pcd_pkg::OFS_PB_FALL:  begin
        rd_data[7:0] = pb_cfg_ff.fall;
        rd_ok        = HAS_PORTB;
      end
      pcd_pkg::OFS_PB_FLAGS: begin
        rd_data[PB_LSB+PB_W-1:PB_LSB] = pb_flags_ff;
        rd_ok                         = HAS_PORTB;
      end
      pcd_pkg::OFS_INT_CTRL: begin
        rd_data[pcd_pkg::CTRL_MEN] = master_en_ff;
        rd_data[pcd_pkg::CTRL_SUM] = summary; // RL7
      end
      pcd_pkg::OFS_EVT_STAT: rd_data[pcd_pkg::EVT_W-1:0] = evt_stat_ff;
      pcd_pkg::OFS_EVT_CLR:  rd_data = '0; // Write-only, reads zero
      pcd_pkg::OFS_EVT_EN:   rd_data[pcd_pkg::EVT_W-1:0] = evt_en_ff;
      default:               rd_ok = 1'b0;
    endcase
    // Absent registers answer an error and never leak state
    if (!rd_ok) begin
      rd_data = '0;
    end
  end

  // Read channel: data is latched at the address edge and offered next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= pcd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_data;
      rresp_ff   <= rd_ok ? pcd_pkg::RESP_OKAY : pcd_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign pin_change_interrupt = irq_core_ff;
  assign wake                 = wake_ff;
  assign irq                  = irq_ff;

endmodule

/* File: test/pcd_checker.sv */
`timescale 1ns/100ps
// Bus timing and core outputs seen from the top module ports
module pcd_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Core side
  input wire logic        sleep,
  input wire logic        pin_change_interrupt,
  input wire logic        wake
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Write steps: both halves taken, a quiet cycle, then the answer
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_walk;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_WR_WALK: assert property (wr_take |=> wr_walk) else $error("write answer out of step");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during answer");
  AST_RD_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer repeated");
  // Wake is the interrupt request qualified by the previous sleep level
  AST_WAKE_EQ: assert property (wake == ($past(sleep) && pin_change_interrupt))
    else $error("wake does not follow sleep and request");
endmodule

bind pcd_top pcd_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep(sleep),
  .pin_change_interrupt(pin_change_interrupt), .wake(wake));

/* File: test/pcd_pins.sv */
`timescale 1ns/100ps
// Outside pin sources and core sleep state
module pcd_pins (
  // Clock
  input wire logic        aclk,
  // Levels asked for by the bench
  input wire logic [5:0]  a_req,
  input wire logic [3:0]  b_req,
  input wire logic        slp_req,
  // Levels seen by the detector
  output logic     [5:0]  porta_pin = 6'h00,
  output logic     [3:0]  portb_pin = 4'h0,
  output logic            sleep = 1'b0
);
  // Pins move at the clock edge after the request, so the detector samples them a cycle later as from outside
  always @(posedge aclk) begin
    porta_pin <= a_req;
    portb_pin <= b_req;
    sleep     <= slp_req;
  end
endmodule

/* File: test/pin_change_interrupt_detector_test.sv */
`timescale 1ns/100ps
module pin_change_interrupt_detector_test;
  // Bench inputs, valued from time zero
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, slp_req = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0, b_req = 4'h0;
  logic [5:0]  a_req = 6'h00;
  // Outputs
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, pci, wake, irq, sleep;
  logic [5:0]  porta_pin;
  logic [3:0]  portb_pin;
  int          n_fail = 0, comparisons = 0, cycles = 0;
  // Ordinary case: enables written, pins before and after, flags expected
  typedef struct packed { logic [7:0] rise, fall; logic [5:0] from, to, flags; } pcd_row_s;
  pcd_row_s rows [6] = '{'{8'hFF, 8'h00, 6'h00, 6'h15, 6'h15}, '{8'h00, 8'hFF, 6'h3F, 6'h2A, 6'h15},
    '{8'h00, 8'h00, 6'h00, 6'h3F, 6'h00}, '{8'h3F, 8'h3F, 6'h0F, 6'h30, 6'h3F},
    '{8'h01, 8'h02, 6'h02, 6'h01, 6'h03}, '{8'h02, 8'h01, 6'h02, 6'h01, 6'h00}};

  pcd_top #(.HAS_PORTB(1'b1)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .porta_pin(porta_pin), .portb_pin(portb_pin), .sleep(sleep), .pin_change_interrupt(pci),
    .wake(wake), .irq(irq));
  pcd_pins u_pins (.aclk(aclk), .a_req(a_req), .b_req(b_req), .slp_req(slp_req),
    .porta_pin(porta_pin), .portb_pin(portb_pin), .sleep(sleep));

  // Clock and hang guard
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // Write: both halves offered together, each released when taken; bready may come lag cycles late
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pcd_pkg::RESP_OKAY,
                    input int lag = 0);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n >= lag && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    bready <= 1'b0;
    chk_word({30'h0, bresp}, {30'h0, er});
  endtask
  // Read and compare data and response; rready may come lag cycles late so the data must stand
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = pcd_pkg::RESP_OKAY,
                     input int lag = 0);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n >= lag && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1));
    rready <= 1'b0;
    chk_word(rdata, exp);
    chk_word({30'h0, rresp}, {30'h0, er});
  endtask
  // Long enough for a pin change to reach flags and outputs
  task automatic settle;
    repeat (6) @(posedge aclk);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(pcd_pkg::OFS_PA_RISE, 32'h0);
    rdc(pcd_pkg::OFS_PA_FALL, 32'h0);
    rdc(pcd_pkg::OFS_PA_FLAGS, 32'h0);
    foreach (rows[i]) begin
      a_req <= rows[i].from;
      settle();
      wr(pcd_pkg::OFS_PA_RISE, {24'h0, rows[i].rise});
      wr(pcd_pkg::OFS_PA_FALL, {24'h0, rows[i].fall});
      wr(pcd_pkg::OFS_PA_FLAGS, 32'h0);
      a_req <= rows[i].to;
      settle();
      rdc(pcd_pkg::OFS_PA_RISE, {24'h0, rows[i].rise & 8'h3F});
      rdc(pcd_pkg::OFS_PA_FALL, {24'h0, rows[i].fall & 8'h3F});
      rdc(pcd_pkg::OFS_PA_FLAGS, {26'h0, rows[i].flags});
    end
    // Summary with the master enable off, then on
    wr(pcd_pkg::OFS_PA_RISE, 32'h01);
    wr(pcd_pkg::OFS_PA_FALL, 32'h01);
    a_req <= 6'h00;
    settle();
    rdc(pcd_pkg::OFS_INT_CTRL, 32'h01);
    chk_bit(pci, 1'b0);
    wr(pcd_pkg::OFS_INT_CTRL, 32'h08);
    repeat (3) @(posedge aclk);
    chk_bit(pci, 1'b1);
    wr(pcd_pkg::OFS_PB_RISE, 32'hF0);
    b_req <= 4'h1;
    settle();
    rdc(pcd_pkg::OFS_PB_FLAGS, 32'h10);
    // Zero written to all port A flags, only one of which is set; port B keeps the summary up
    wr(pcd_pkg::OFS_PA_FLAGS, (32'h01 ^ 32'hFF) & 32'h01);
    rdc(pcd_pkg::OFS_PA_FLAGS, 32'h0);
    rdc(pcd_pkg::OFS_INT_CTRL, 32'h09);
    wr(pcd_pkg::OFS_PB_FLAGS, 32'h0);
    rdc(pcd_pkg::OFS_INT_CTRL, 32'h08);
    chk_bit(pci, 1'b0);
    // Edge during sleep wakes and is already flagged
    slp_req <= 1'b1;
    a_req <= 6'h01;
    settle();
    chk_bit(wake, 1'b1);
    rdc(pcd_pkg::OFS_PA_FLAGS, 32'h01, pcd_pkg::RESP_OKAY, 3);
    slp_req <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_bit(wake, 1'b0);
    // Event status, enable, clear and the level interrupt
    rdc(pcd_pkg::OFS_EVT_STAT, 32'h03);
    wr(pcd_pkg::OFS_EVT_EN, 32'h01, pcd_pkg::RESP_OKAY, 3);
    repeat (3) @(posedge aclk);
    chk_bit(irq, 1'b1);
    wr(pcd_pkg::OFS_EVT_CLR, 32'h01);
    rdc(pcd_pkg::OFS_EVT_STAT, 32'h02);
    chk_bit(irq, 1'b0);
    wr(pcd_pkg::OFS_EVT_EN, 32'h02);
    repeat (3) @(posedge aclk);
    chk_bit(irq, 1'b1);
    wr(pcd_pkg::OFS_EVT_CLR, 32'h03);
    repeat (3) @(posedge aclk);
    chk_bit(irq, 1'b0);
    // Clearing write landing on the detect edge, then one cycle after it
    for (int k = 0; k < 2; k++) begin
      wr(pcd_pkg::OFS_PA_FLAGS, 32'h0);
      a_req <= a_req ^ 6'h01;
      repeat (1 + k) @(posedge aclk);
      wr(pcd_pkg::OFS_PA_FLAGS, 32'h0);
      settle();
      rdc(pcd_pkg::OFS_PA_FLAGS, (k == 0) ? 32'h01 : 32'h00);
    end
    rdc(8'h40, 32'h0, pcd_pkg::RESP_SLVERR);
    wr(8'h40, 32'hFF, pcd_pkg::RESP_SLVERR);
    // Reset in mid-run restores the control register and the port A rise enable
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(pcd_pkg::OFS_INT_CTRL, 32'h0);
    rdc(pcd_pkg::OFS_PA_RISE, 32'h0);
    give_verdict();
  end
endmodule
